/* File: core/pe_map.svh */
`ifndef PE_MAP_SVH
`define PE_MAP_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PE_CLK_NS        10
`define PE_BLC_US        100
`define PE_BLC_CYC       ((`PE_BLC_US * 1000) / `PE_CLK_NS)
`define PE_LOAD_MARGIN   8
`define PE_WR_MS         5
`define PE_BUSY_CYC      ((`PE_WR_MS * 2000000) / `PE_CLK_NS)
`define PE_GLITCH_NS     5
`define PE_WE_CYC        (((`PE_GLITCH_NS + `PE_CLK_NS - 1) / `PE_CLK_NS) + 1)
`define PE_ACC_NS        120
`define PE_RD_CYC        ((`PE_ACC_NS + `PE_CLK_NS - 1) / `PE_CLK_NS)

// ----------------------------------------
// field positions and counts
// ----------------------------------------
`define PE_ROW_LSB       7
`define PE_MSB_BIT       7
`define PE_ALT_BIT       6
`define PE_CONFIRM_READS 2'h2
`define PE_PROT_LAST     3'h2
`define PE_ERASE_LAST    3'h5

// ----------------------------------------
// command sequences, {addr, data} per entry, first entry in the top bits
// ----------------------------------------
`define PE_PROT_SEQ      72'h11_1101_2222_0233_3303
`define PE_ERASE_SEQ     144'h1111_1122_2212_3333_1344_4414_5555_1566_6616

`endif

/* File: core/pe_pkg.sv */
`default_nettype none

package pe_pkg;

    typedef enum logic [1:0] {
        PE_OP_READ  = 2'b00,
        PE_OP_WRITE = 2'b01,
        PE_OP_ERASE = 2'b10
    } pe_op_e;

    typedef struct packed {
        pe_op_e      op;
        logic        protect;
        logic        last;
        logic [15:0] addr;
        logic [7:0]  data;
    } pe_cmd_s;

    typedef struct packed {
        logic [7:0] data;
        logic       timeout;
    } pe_rsp_s;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [15:0] addr;
        logic [7:0]  dq_o;
        logic        dq_oe;
    } pe_pins_s;

    typedef enum logic [1:0] {
        PE_CY_IDLE   = 2'b00,
        PE_CY_SETUP  = 2'b01,
        PE_CY_STROBE = 2'b10,
        PE_CY_HOLD   = 2'b11
    } pe_cyc_e;

    typedef struct packed {
        pe_cyc_e    st;
        logic       wr;
        logic [3:0] cnt;
        pe_pins_s   pins;
        logic [7:0] rdata;
        logic       done;
    } pe_cyc_s;

    typedef enum logic [2:0] {
        PE_ST_IDLE = 3'b000,
        PE_ST_READ = 3'b001,
        PE_ST_SEQ  = 3'b010,
        PE_ST_DATA = 3'b011,
        PE_ST_LOAD = 3'b100,
        PE_ST_POLL = 3'b101
    } pe_st_e;

    typedef struct packed {
        pe_st_e      st;
        logic        erase;
        logic [2:0]  idx;
        logic        pend;
        pe_cmd_s     cmd;
        logic [8:0]  row;
        logic [23:0] gap;
        logic [23:0] busy;
        logic        have_prev;
        logic        prev_alt;
        logic [1:0]  conf;
        pe_rsp_s     rsp;
        logic        rsp_valid;
    } pe_ctl_s;

endpackage : pe_pkg

`default_nettype wire

/* File: core/pe_bus_cycle.sv */
`include "pe_map.svh"
`default_nettype none

module pe_bus_cycle import pe_pkg::*; #(
    parameter int WE_CYC = `PE_WE_CYC,
    parameter int RD_CYC = `PE_RD_CYC
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // cycle request
    input  wire logic       start,
    input  wire logic       wr,
    input  wire logic [15:0] addr,
    input  wire logic [7:0] wdata,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rdata,
    // device pins
    output pe_pins_s        pins,
    input  wire logic [7:0] dq_i
);

    localparam pe_cyc_s CYC_RST = '{st: PE_CY_IDLE, wr: 1'b0, cnt: 4'h0,
        pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 16'h0000,
                dq_o: 8'h00, dq_oe: 1'b0},
        rdata: 8'h00, done: 1'b0};

    pe_cyc_s s_r;
    pe_cyc_s s_nxt;

    // ----------------------------------------
    // one strobe cycle: chip select first, strobe last
    // ----------------------------------------
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            PE_CY_IDLE: begin
                if (start) begin
                    s_nxt.st         = PE_CY_SETUP;
                    s_nxt.wr         = wr;
                    s_nxt.pins.ce_n  = 1'b0;
                    s_nxt.pins.addr  = addr;
                    s_nxt.pins.dq_o  = wdata;
                    s_nxt.pins.dq_oe = wr;
                end
            end
            PE_CY_SETUP: begin
                s_nxt.st  = PE_CY_STROBE;
                s_nxt.cnt = 4'h0;
                // write strobe falls last, so it latches the held address
                if (s_r.wr) begin
                    s_nxt.pins.we_n = 1'b0;
                end else begin
                    s_nxt.pins.oe_n = 1'b0;
                end
            end
            PE_CY_STROBE: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (s_r.cnt == (s_r.wr ? 4'(WE_CYC - 1) : 4'(RD_CYC - 1))) begin
                    s_nxt.st        = PE_CY_HOLD;
                    s_nxt.pins.we_n = 1'b1;
                    s_nxt.pins.oe_n = 1'b1;
                    s_nxt.rdata     = s_r.wr ? s_r.rdata : dq_i;
                end
            end
            PE_CY_HOLD: begin
                // data still driven one cycle past the strobe rise
                s_nxt.st         = PE_CY_IDLE;
                s_nxt.pins.ce_n  = 1'b1;
                s_nxt.pins.dq_oe = 1'b0;
                s_nxt.done       = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r <= CYC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy  = (s_r.st != PE_CY_IDLE);
    assign done  = s_r.done;
    assign rdata = s_r.rdata;
    assign pins  = s_r.pins;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_dq_no_fight: assert property (@(posedge core_clk) disable iff (reset)
        pins.dq_oe |-> pins.oe_n) else $error("host drives data while output gate low");
    chk_write_inhibit: assert property (@(posedge core_clk) disable iff (reset)
        !pins.we_n |-> (pins.oe_n && !pins.ce_n)) else $error("write strobe in inhibit state");
    chk_we_width: assert property (@(posedge core_clk) disable iff (reset)
        $fell(pins.we_n) |=> !pins.we_n) else $error("write strobe pulse too short");
    chk_addr_held: assert property (@(posedge core_clk) disable iff (reset)
        (!pins.we_n && $past(!pins.we_n)) |-> $stable(pins.addr))
        else $error("address moved during write strobe");
    chk_data_at_rise: assert property (@(posedge core_clk) disable iff (reset)
        $rose(pins.we_n) |-> (pins.dq_oe && $stable(pins.dq_o) && !pins.ce_n))
        else $error("data not held at strobe rise");
    chk_ce_standby: assert property (@(posedge core_clk) disable iff (reset)
        pins.ce_n |-> (pins.oe_n && pins.we_n)) else $error("strobe active while deselected");

endmodule : pe_bus_cycle

`default_nettype wire

/* File: core/pe_host_ctrl.sv */
// Summary of operation
// - read data only with select and gate low
// - page load takes one to 128 bytes
// - protection prefix leaves device protected afterwards
// - only status reads during internal write
// - all page bytes share row bits 15..7
// - next byte within load interval extends page
// - six-byte sequence erases whole array to ones
// - only alternating-bit read during chip erase
// - confirm apparent completion with two more reads
`include "pe_map.svh"
`default_nettype none

module pe_host_ctrl import pe_pkg::*; #(
    parameter int           BLC_CYC   = `PE_BLC_CYC,
    parameter int           BUSY_CYC  = `PE_BUSY_CYC,
    parameter int           WE_CYC    = `PE_WE_CYC,
    parameter int           RD_CYC    = `PE_RD_CYC,
    parameter logic [71:0]  PROT_SEQ  = `PE_PROT_SEQ,
    parameter logic [143:0] ERASE_SEQ = `PE_ERASE_SEQ
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // command stream
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire pe_cmd_s    cmd,
    // answers
    output logic            rsp_valid,
    output pe_rsp_s         rsp,
    // device pins
    output pe_pins_s        pins,
    input  wire logic [7:0] dq_i
);

    pe_ctl_s     s_r;
    pe_ctl_s     s_nxt;
    logic        take;
    logic        start;
    logic        bwr;
    logic [15:0] baddr;
    logic [7:0]  bwdata;
    logic        bbusy;
    logic        bdone;
    logic [7:0]  brdata;
    logic [23:0] seq_word;
    logic        status_ok;

    // ----------------------------------------
    // bus cycle engine
    // ----------------------------------------
    pe_bus_cycle #(
        .WE_CYC (WE_CYC),
        .RD_CYC (RD_CYC)
    ) u_cycle (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (start),
        .wr       (bwr),
        .addr     (baddr),
        .wdata    (bwdata),
        .busy     (bbusy),
        .done     (bdone),
        .rdata    (brdata),
        .pins     (pins),
        .dq_i     (dq_i)
    );

    // ----------------------------------------
    // request side
    // ----------------------------------------
    // a byte for another row is held off; the page then times out and
    // the byte opens a fresh page once the device is idle again
    assign cmd_ready = (s_r.st == PE_ST_IDLE) ||
                       ((s_r.st == PE_ST_LOAD) && (cmd.op == PE_OP_WRITE) &&
                        (cmd.addr[15:`PE_ROW_LSB] == s_r.row));
    assign take      = cmd_valid && cmd_ready;

    // no new poll read once the give-up count is reached, or a stray read
    // would still run after the answer and feed the next command
    assign start = !s_r.pend && !bbusy &&
                   ((s_r.st == PE_ST_READ) || (s_r.st == PE_ST_SEQ) ||
                    (s_r.st == PE_ST_DATA) ||
                    ((s_r.st == PE_ST_POLL) && (s_r.busy < 24'(BUSY_CYC - 1))));

    always_comb begin
        int k;
        k = s_r.erase ? int'(`PE_ERASE_LAST - s_r.idx) : int'(`PE_PROT_LAST - s_r.idx);
        seq_word = s_r.erase ? ERASE_SEQ[k * 24 +: 24] : PROT_SEQ[k * 24 +: 24];
    end

    assign bwr    = (s_r.st == PE_ST_SEQ) || (s_r.st == PE_ST_DATA);
    assign baddr  = (s_r.st == PE_ST_SEQ) ? seq_word[23:8] : s_r.cmd.addr;
    assign bwdata = (s_r.st == PE_ST_SEQ) ? seq_word[7:0] : s_r.cmd.data;

    // erase is judged by the alternating bit alone; a page write by the
    // true msb of the last byte loaded
    assign status_ok = s_r.erase ?
        (s_r.have_prev && (s_r.prev_alt == brdata[`PE_ALT_BIT])) :
        (brdata[`PE_MSB_BIT] == s_r.cmd.data[`PE_MSB_BIT]);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp_valid = 1'b0;
        if (start) begin
            s_nxt.pend = 1'b1;
        end
        if (bdone) begin
            s_nxt.pend = 1'b0;
        end
        unique case (s_r.st)
            PE_ST_IDLE: begin
                if (take) begin
                    s_nxt.cmd       = cmd;
                    s_nxt.row       = cmd.addr[15:`PE_ROW_LSB];
                    s_nxt.idx       = 3'h0;
                    s_nxt.busy      = 24'h00_0000;
                    s_nxt.conf      = 2'h0;
                    s_nxt.have_prev = 1'b0;
                    s_nxt.erase     = (cmd.op == PE_OP_ERASE);
                    unique case (cmd.op)
                        PE_OP_READ:  s_nxt.st = PE_ST_READ;
                        PE_OP_WRITE: s_nxt.st = cmd.protect ? PE_ST_SEQ : PE_ST_DATA;
                        PE_OP_ERASE: s_nxt.st = PE_ST_SEQ;
                        default:     s_nxt.st = PE_ST_IDLE;
                    endcase
                end
            end
            PE_ST_READ: begin
                if (bdone) begin
                    s_nxt.st          = PE_ST_IDLE;
                    s_nxt.rsp         = '{data: brdata, timeout: 1'b0};
                    s_nxt.rsp_valid   = 1'b1;
                end
            end
            PE_ST_SEQ: begin
                if (bdone) begin
                    s_nxt.idx = s_r.idx + 3'h1;
                    if (s_r.idx == (s_r.erase ? `PE_ERASE_LAST : `PE_PROT_LAST)) begin
                        s_nxt.st = s_r.erase ? PE_ST_POLL : PE_ST_DATA;
                    end
                end
            end
            PE_ST_DATA: begin
                if (bdone) begin
                    s_nxt.gap = 24'h00_0000;
                    // status is valid from this strobe rise on
                    s_nxt.st  = s_r.cmd.last ? PE_ST_POLL : PE_ST_LOAD;
                end
            end
            PE_ST_LOAD: begin
                s_nxt.gap = s_r.gap + 24'h00_0001;
                if (take) begin
                    s_nxt.cmd = cmd;
                    s_nxt.st  = PE_ST_DATA;
                end else if (s_r.gap == 24'(BLC_CYC - `PE_LOAD_MARGIN)) begin
                    // stop early so a late byte never lands after the device closed
                    s_nxt.st = PE_ST_POLL;
                end
            end
            PE_ST_POLL: begin
                s_nxt.busy = s_r.busy + 24'h00_0001;
                if (bdone) begin
                    s_nxt.have_prev = 1'b1;
                    s_nxt.prev_alt  = brdata[`PE_ALT_BIT];
                    if (!status_ok) begin
                        s_nxt.conf = 2'h0;
                    end else if (s_r.conf == `PE_CONFIRM_READS) begin
                        s_nxt.st        = PE_ST_IDLE;
                        s_nxt.rsp       = '{data: brdata, timeout: 1'b0};
                        s_nxt.rsp_valid = 1'b1;
                    end else begin
                        s_nxt.conf = s_r.conf + 2'h1;
                    end
                end else if (!bbusy && !s_r.pend &&
                             (s_r.busy >= 24'(BUSY_CYC - 1))) begin
                    // device never finished: give up at twice the typical time
                    s_nxt.st        = PE_ST_IDLE;
                    s_nxt.rsp       = '{data: 8'h00, timeout: 1'b1};
                    s_nxt.rsp_valid = 1'b1;
                end
            end
            default: s_nxt.st = PE_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rsp_valid = s_r.rsp_valid;
    assign rsp       = s_r.rsp;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence poll_exit;
        (s_r.st == PE_ST_POLL) ##1 (s_r.st == PE_ST_IDLE);
    endsequence

    sequence seq_exit;
        (s_r.st == PE_ST_SEQ) ##1 (s_r.st != PE_ST_SEQ);
    endsequence

    chk_load_gap: assert property (@(posedge core_clk) disable iff (reset)
        (s_r.st == PE_ST_LOAD) |-> (s_r.gap < 24'(BLC_CYC)))
        else $error("page load gap exceeds byte load interval");
    chk_busy_ready: assert property (@(posedge core_clk) disable iff (reset)
        (s_r.st == PE_ST_POLL) |-> (!cmd_ready && !bwr))
        else $error("request accepted during internal cycle");
    chk_row_same: assert property (@(posedge core_clk) disable iff (reset)
        (take && (s_r.st == PE_ST_LOAD)) |-> (cmd.addr[15:`PE_ROW_LSB] == s_r.row))
        else $error("page byte from another row");
    chk_seq_count: assert property (@(posedge core_clk) disable iff (reset)
        seq_exit |-> ($past(s_r.idx) == (s_r.erase ? `PE_ERASE_LAST : `PE_PROT_LAST)))
        else $error("command sequence length wrong");
    chk_answer_idle: assert property (@(posedge core_clk) disable iff (reset)
        rsp_valid |-> (!bbusy && !s_r.pend))
        else $error("answer given while a bus cycle is still running");
    chk_poll_confirm: assert property (@(posedge core_clk) disable iff (reset)
        (poll_exit ##0 !s_r.rsp.timeout) |-> ($past(s_r.conf) == `PE_CONFIRM_READS))
        else $error("completion reported without two confirming reads");

endmodule : pe_host_ctrl

`default_nettype wire

/* File: verification/pe_dev_model.sv */
`include "pe_map.svh"
`default_nettype none

module pe_dev_model #(
    parameter int TMO_NS  = 300,
    parameter int WR_NS   = 3000,
    parameter int SLOW_NS = 40000
) (
    // strobes, address and bus from the host
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  dq,
    // scenario controls
    input  wire logic        slow,
    input  wire logic        glitch,
    // device side
    output logic [7:0]       q,
    output logic             q_drv,
    output logic             prot,
    output logic             busy,
    output var int           progs,
    output var int           viol
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]   mem [0:65535];
    logic [7:0]   pbuf [0:127];
    logic [127:0] hit;
    logic [15:0]  la;
    logic [15:0]  last_a;
    logic [7:0]   last_d;
    logic [8:0]   row;
    logic         loading;
    logic         erasing;
    logic         pk;
    logic         ek;
    logic         tog;
    logic         gl_used;
    int           n;
    int           nbuf;
    time          t_fall;
    time          t_rise;
    time          t_end;
    wire          wr_n = ce_n | we_n | ~oe_n;

    function automatic logic [23:0] ent(input logic [143:0] s, input int i, input int k);
        return s[24 * k - 1 - 24 * i -: 24];
    endfunction : ent

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hff;
        end
        {loading, erasing, busy, prot, q_drv, tog, gl_used} = '0;
        {progs, viol, n, nbuf} = '0;
        q = 8'h00;
        last_a = 16'h0000;
        last_d = 8'h00;
    end

    task automatic load(input logic [15:0] a, input logic [7:0] d);
        logic pm;
        logic em;
        if (!loading) begin
            {pk, ek, n, nbuf, hit, gl_used, tog} = {2'b11, 64'h0, 128'h0, 2'b00};
        end
        pm = n < 3 && pk && {a, d} == ent(`PE_PROT_SEQ, n, 3);
        em = n < 6 && ek && {a, d} == ent(`PE_ERASE_SEQ, n, 6);
        pk = (n < 3) ? pm : pk;
        ek = (n < 6) ? em : ek;
        n = n + 1;
        if (!pm && !em) begin
            if (nbuf > 0 && a[15:7] != row) viol++;
            pbuf[a[6:0]] = d;
            hit[a[6:0]] = 1'b1;
            nbuf++;
            row = a[15:7];
            last_a = a;
            last_d = d;
        end
        loading = 1'b1;
        t_rise = $time;
    endtask : load

    always @(negedge wr_n) begin
        t_fall = $time;
        la = addr;
    end

    // short pulses and loads during an internal cycle change nothing
    always @(posedge wr_n) begin
        if (!busy && $time - t_fall >= `PE_GLITCH_NS) load(la, dq);
    end

    always #5 begin
        if (loading && wr_n && $time - t_rise >= TMO_NS) begin
            loading = 1'b0;
            erasing = ek && n == 6;
            if (pk && n >= 3) prot = 1'b1;
            t_end = $time + (slow ? SLOW_NS : WR_NS);
            busy = 1'b1;
        end else if (busy && $time >= t_end) begin
            for (int i = 0; i < 65536; i++) begin
                if (erasing) mem[i] = 8'hff;
            end
            for (int i = 0; i < 128; i++) begin
                if (!erasing && nbuf > 0)
                    mem[{row, i[6:0]}] = hit[i] ? pbuf[i] : 8'hff;
            end
            progs++;
            busy = 1'b0;
            erasing = 1'b0;
        end
    end

    // released bus shows the inverse of the last value, never a held copy
    always @(ce_n or oe_n or we_n) begin
        if (!ce_n && !oe_n && we_n) begin
            if (!q_drv && (loading || busy)) begin
                tog = ~tog;
                if (!ek && addr != last_a) viol++;
                q = {last_d[7] ^ !(glitch && !gl_used), tog, last_d[5:0]};
                if (glitch) gl_used = 1'b1;
            end else if (!q_drv) begin
                q = mem[addr];
            end
            q_drv = 1'b1;
        end else if (q_drv) begin
            q_drv = 1'b0;
            q = ~q;
        end
    end

endmodule : pe_dev_model

`default_nettype wire

/* File: verification/test_pe_host_ctrl.sv */
`default_nettype none

module test_pe_host_ctrl import pe_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk  = 1'b0;
    logic       reset     = 1'b1;
    logic       cmd_valid = 1'b0;
    pe_cmd_s    cmd       = '0;
    logic       slow      = 1'b0;
    logic       glitch    = 1'b0;
    logic       cmd_ready;
    logic       rsp_valid;
    pe_rsp_s    rsp;
    pe_pins_s   pins;
    logic [7:0] dev_q;
    logic       prot;
    logic       dev_busy;
    int         progs;
    int         viol;
    int         fails = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    wire [7:0]  dq_i = pins.dq_oe ? pins.dq_o : dev_q;

    always #5 core_clk = ~core_clk;

    pe_host_ctrl #(.BLC_CYC(64), .BUSY_CYC(2000)) dut_u (
        .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_i(dq_i));

    // device time-out kept at twice the host's 64-cycle byte interval
    pe_dev_model #(.TMO_NS(1280)) dev_u (
        .ce_n(pins.ce_n), .oe_n(pins.oe_n), .we_n(pins.we_n), .addr(pins.addr),
        .dq(dq_i), .slow(slow), .glitch(glitch), .q(dev_q), .q_drv(), .prot(prot),
        .busy(dev_busy), .progs(progs), .viol(viol));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one edge passes after each take so valid is never reassigned in one step
    task automatic send(input pe_op_e o, input logic pr, input logic lst,
                        input logic [15:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cmd_valid <= 1'b1;
        cmd <= '{op: o, protect: pr, last: lst, addr: a, data: d};
        @(posedge core_clk);
        while (cmd_ready !== 1'b1 && k < 20000) begin
            k++;
            @(posedge core_clk);
        end
        if (k >= 20000) check("request taken", 16'h0001, 16'h0000);
        cmd_valid <= 1'b0;
        @(posedge core_clk);
    endtask : send

    task automatic wait_rsp(input int lim);
        int k;
        k = 0;
        while (rsp_valid !== 1'b1 && k < lim) begin
            k++;
            @(posedge core_clk);
        end
        if (k >= lim) check("answer arrived", 16'h0001, 16'h0000);
    endtask : wait_rsp

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        send(PE_OP_READ, 1'b0, 1'b1, a, 8'h00);
        wait_rsp(100);
        check("read data", {8'h00, exp}, {8'h00, rsp.data});
    endtask : rd_chk

    task automatic write_done(input int p0, input logic [7:0] st);
        wait_rsp(5000);
        check("poll timeout", 16'h0000, {15'h0000, rsp.timeout});
        check("poll data", {8'h00, st}, {8'h00, rsp.data});
        check("programs", 16'(p0 + 1), 16'(progs));
    endtask : write_done

    task automatic t_page();
        int p0;
        p0 = progs;
        send(PE_OP_WRITE, 1'b0, 1'b0, 16'h0280, 8'h12);
        send(PE_OP_WRITE, 1'b0, 1'b0, 16'h0281, 8'h34);
        send(PE_OP_WRITE, 1'b0, 1'b0, 16'h0281, 8'h35);
        send(PE_OP_WRITE, 1'b0, 1'b1, 16'h0283, 8'h56);
        write_done(p0, 8'h56);
        rd_chk(16'h0280, 8'h12);
        rd_chk(16'h0281, 8'h35);
        rd_chk(16'h0282, 8'hff);
    endtask : t_page

    task automatic t_rows();
        int p0;
        p0 = progs;
        send(PE_OP_WRITE, 1'b0, 1'b0, 16'h0400, 8'h0a);
        send(PE_OP_WRITE, 1'b0, 1'b0, 16'h0500, 8'h0b);
        write_done(p0 + 1, 8'h0b);
        rd_chk(16'h0400, 8'h0a);
        rd_chk(16'h0500, 8'h0b);
    endtask : t_rows

    task automatic t_full_page();
        int p0;
        p0 = progs;
        for (int i = 0; i < 128; i++) begin
            send(PE_OP_WRITE, 1'b0, i == 127, {9'h00c, 7'(i)}, 8'(i));
        end
        write_done(p0, 8'h7f);
        rd_chk(16'h0600, 8'h00);
        rd_chk(16'h0655, 8'h55);
    endtask : t_full_page

    task automatic t_protect();
        check("protected before", 16'h0000, {15'h0000, prot});
        send(PE_OP_WRITE, 1'b1, 1'b1, 16'h0700, 8'h42);
        write_done(progs, 8'h42);
        check("protected after", 16'h0001, {15'h0000, prot});
        rd_chk(16'h0700, 8'h42);
    endtask : t_protect

    task automatic t_erase();
        send(PE_OP_ERASE, 1'b0, 1'b0, 16'h0000, 8'h00);
        write_done(progs, 8'hff);
        rd_chk(16'h0280, 8'hff);
        rd_chk(16'h0700, 8'hff);
    endtask : t_erase

    task automatic t_slow();
        int k;
        k = 0;
        slow <= 1'b1;
        send(PE_OP_WRITE, 1'b0, 1'b1, 16'h0800, 8'h11);
        wait_rsp(5000);
        check("slow timeout", 16'h0001, {15'h0000, rsp.timeout});
        while (dev_busy !== 1'b0 && k < 5000) begin
            k++;
            @(posedge core_clk);
        end
        slow <= 1'b0;
        rd_chk(16'h0800, 8'h11);
    endtask : t_slow

    // one early status read looks complete; the host must confirm it
    task automatic t_glitch();
        glitch <= 1'b1;
        send(PE_OP_WRITE, 1'b0, 1'b1, 16'h0900, 8'h22);
        write_done(progs, 8'h22);
        check("device idle at answer", 16'h0000, {15'h0000, dev_busy});
        glitch <= 1'b0;
    endtask : t_glitch

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_page();
        t_rows();
        t_full_page();
        t_protect();
        t_erase();
        t_slow();
        t_glitch();
        check("host rule breaches", 16'h0000, 16'(viol));
        report_and_stop();
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            $display("MISMATCH run length expected finish seen limit");
            report_and_stop();
        end
    end

endmodule : test_pe_host_ctrl

`default_nettype wire
